// ### rtl/aic_pkg.sv
// Purpose: shared constants for the converter group init and wire-check block
// Assumes: 100 MHz sys_clk, 8-bit byte address, 32-bit data
// Notes: most register fields are listed here by bit position; anaen, qen, iclass and qch bits are coded in aic_ctrl
package aic_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] ADR_ANCFG = 8'h00;
    localparam logic [7:0] ADR_ARBCFG = 8'h04;
    localparam logic [7:0] ADR_GLOBAL_CONFIG = 8'h08;
    localparam logic [7:0] ADR_ARBPR = 8'h0c;
    localparam logic [7:0] ADR_QMR0 = 8'h10;
    localparam logic [7:0] ADR_ICLASS0 = 8'h14;
    localparam logic [7:0] ADR_RCR0 = 8'h18;
    localparam logic [7:0] ADR_QINR0 = 8'h1c;
    localparam logic [7:0] ADR_RES0 = 8'h20;
    localparam logic [7:0] ADR_CHCTR = 8'h40;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int DIV_LSB = 20;
    localparam int DIV_MSB = 22;
    localparam int CAL_BIT = 28;
    localparam int WU_BIT = 29;
    localparam int START_BIT = 31;
    localparam int USC_BIT = 1;
    localparam int SLOT0_BIT = 24;
    localparam int SRQEN_BIT = 31;
    localparam int REP_BIT = 5;
    localparam int RESVAL_BIT = 31;
    localparam int WEN_BIT = 0;
    localparam int WLEV_BIT = 1;
    localparam logic [1:0] ANA_ON = 2'h3;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] ICLASS_RST = 3'h0;
    localparam logic [1:0] ANAEN_RST = 2'h0;
    // ----------------------------------------
    // sizes and timing
    // ----------------------------------------
    localparam int NCH = 4;
    localparam int DW = 12;
    localparam int CLK_NS = 10;
    localparam int T_WU_NS = 5000;
    localparam int WU_CYC = (T_WU_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAL_STEPS = 8;
    localparam int CAL_STEP_TICKS = 16;
    localparam int CAL_TICKS = CAL_STEPS * CAL_STEP_TICKS;
    localparam int SYNC_TICKS = 16;
    localparam int PREP_TICKS = 2;
    localparam int SAMPLE_BASE = 2;
    localparam int CONV_TICKS = 12;

    typedef enum logic [1:0] {CV_IDLE, CV_PREP, CV_SAMPLE, CV_CONV} aic_conv_t;
endpackage : aic_pkg

// ### rtl/aic_clkdiv.sv
// Purpose: analog clock enable, sys_clk divided by field value plus one
// Assumes: div is a register output on the same clock
// Notes: a change of div applies to the running count; a count at or past the new value wraps at once
`timescale 1ns/1ps
module aic_clkdiv (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] div,
    output logic tick
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } aic_div_t;

    aic_div_t s_ff;
    aic_div_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (s_ff.cnt >= div)
        begin
            nxt_s.cnt = 3'h0;
            nxt_s.tick = 1'b1;
        end
        else
        begin
            nxt_s.cnt = s_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;
endmodule : aic_clkdiv

// ### rtl/aic_ctrl.sv
// Purpose: converter group start-up sequence, calibration and conversion control
// Assumes: register port strobes are one cycle, ana_data comes from off-domain
// Notes: calibration and conversion timing is counted in analog clock enables, wakeup time in sys_clk
`timescale 1ns/1ps
module aic_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [11:0] ana_data,
    output logic [4:0] ana_chan,
    output logic ana_prechg,
    output logic ana_prelvl,
    output logic ana_sample,
    output logic srq0
);
    typedef struct packed {
        logic [2:0] div;
        logic [1:0] anaen;
        logic [9:0] wucnt;
        logic unsynchronized_trim_select;
        logic slot0;
        logic qen;
        logic [2:0] iclass;
        logic srqen;
        logic [4:0] qch;
        logic qrep;
        logic qval;
        logic [aic_pkg::NCH-1:0] wen;
        logic [aic_pkg::NCH-1:0] wlev;
        logic calact;
        logic caldone;
        logic calwait;
        logic [3:0] calstep;
        logic [4:0] calcnt;
        logic [8:0] caltk;
        logic [3:0] phase;
        aic_pkg::aic_conv_t st;
        logic [7:0] cnt;
        logic [4:0] chan;
        logic prechg;
        logic prelvl;
        logic sample;
        logic [11:0] res;
        logic resval;
        logic srq;
        logic [31:0] rdata;
        logic [11:0] din1;
        logic [11:0] din2;
    } aic_state_t;

    aic_state_t s_ff;
    aic_state_t nxt_s;
    logic tick;
    logic ana_on;
    logic ready;
    logic wire_sel;

    aic_clkdiv u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .div(s_ff.div),
        .tick(tick)
    );

    assign ana_on = (s_ff.anaen == aic_pkg::ANA_ON);
    assign ready = s_ff.caldone && ana_on && s_ff.slot0 && s_ff.qen && s_ff.qval;
    assign wire_sel = (s_ff.qch < 5'(aic_pkg::NCH)) && s_ff.wen[s_ff.qch[1:0]];

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.srq = 1'b0;
        nxt_s.rdata = 32'h0;
        nxt_s.din1 = ana_data;
        nxt_s.din2 = s_ff.din1;
        if (tick)
        begin
            nxt_s.phase = s_ff.phase + 4'h1;
        end
        // ----------------------------------------
        // wakeup time status
        // ----------------------------------------
        // only reported; waiting before calibration stays with software
        if (!ana_on)
        begin
            nxt_s.wucnt = 10'h0;
        end
        else if (s_ff.wucnt < 10'(aic_pkg::WU_CYC))
        begin
            nxt_s.wucnt = s_ff.wucnt + 10'h1;
        end
        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (wr)
        begin
            case (addr)
                aic_pkg::ADR_ANCFG: nxt_s.div = wdata[aic_pkg::DIV_MSB:aic_pkg::DIV_LSB];
                aic_pkg::ADR_ARBCFG: nxt_s.anaen = wdata[1:0];
                aic_pkg::ADR_GLOBAL_CONFIG:
                begin
                    nxt_s.unsynchronized_trim_select = wdata[aic_pkg::USC_BIT];
                    // start is ignored while already calibrating or powered down
                    if (wdata[aic_pkg::START_BIT] && ana_on && !s_ff.calact)
                    begin
                        nxt_s.calact = 1'b1;
                        nxt_s.caldone = 1'b0;
                        nxt_s.calstep = 4'h0;
                        nxt_s.calcnt = 5'h0;
                        nxt_s.caltk = 9'h0;
                        nxt_s.calwait = !wdata[aic_pkg::USC_BIT];
                    end
                end
                aic_pkg::ADR_ARBPR: nxt_s.slot0 = wdata[aic_pkg::SLOT0_BIT];
                aic_pkg::ADR_QMR0: nxt_s.qen = wdata[0];
                aic_pkg::ADR_ICLASS0: nxt_s.iclass = wdata[2:0];
                aic_pkg::ADR_RCR0: nxt_s.srqen = wdata[aic_pkg::SRQEN_BIT];
                aic_pkg::ADR_QINR0:
                begin
                    nxt_s.qch = wdata[4:0];
                    nxt_s.qrep = wdata[aic_pkg::REP_BIT];
                    nxt_s.qval = 1'b1;
                end
                default:
                begin
                    for (int i = 0; i < aic_pkg::NCH; i++)
                    begin
                        if (addr == 8'(aic_pkg::ADR_CHCTR + 8'(4 * i)))
                        begin
                            nxt_s.wen[i] = wdata[aic_pkg::WEN_BIT];
                            nxt_s.wlev[i] = wdata[aic_pkg::WLEV_BIT];
                        end
                    end
                end
            endcase
        end
        // ----------------------------------------
        // register reads
        // ----------------------------------------
        if (rd)
        begin
            case (addr)
                aic_pkg::ADR_ANCFG:
                    nxt_s.rdata[aic_pkg::DIV_MSB:aic_pkg::DIV_LSB] = s_ff.div;
                aic_pkg::ADR_ARBCFG:
                begin
                    nxt_s.rdata[1:0] = s_ff.anaen;
                    nxt_s.rdata[aic_pkg::CAL_BIT] = s_ff.calact;
                    nxt_s.rdata[aic_pkg::WU_BIT] = (s_ff.wucnt == 10'(aic_pkg::WU_CYC));
                end
                aic_pkg::ADR_GLOBAL_CONFIG: nxt_s.rdata[aic_pkg::USC_BIT] = s_ff.unsynchronized_trim_select;
                aic_pkg::ADR_ARBPR: nxt_s.rdata[aic_pkg::SLOT0_BIT] = s_ff.slot0;
                aic_pkg::ADR_QMR0: nxt_s.rdata[0] = s_ff.qen;
                aic_pkg::ADR_ICLASS0: nxt_s.rdata[2:0] = s_ff.iclass;
                aic_pkg::ADR_RCR0: nxt_s.rdata[aic_pkg::SRQEN_BIT] = s_ff.srqen;
                aic_pkg::ADR_QINR0:
                begin
                    nxt_s.rdata[4:0] = s_ff.qch;
                    nxt_s.rdata[aic_pkg::REP_BIT] = s_ff.qrep;
                end
                aic_pkg::ADR_RES0:
                begin
                    nxt_s.rdata[11:0] = s_ff.res;
                    nxt_s.rdata[aic_pkg::RESVAL_BIT] = s_ff.resval;
                    nxt_s.resval = 1'b0;
                end
                default:
                begin
                    for (int i = 0; i < aic_pkg::NCH; i++)
                    begin
                        if (addr == 8'(aic_pkg::ADR_CHCTR + 8'(4 * i)))
                        begin
                            nxt_s.rdata[aic_pkg::WEN_BIT] = s_ff.wen[i];
                            nxt_s.rdata[aic_pkg::WLEV_BIT] = s_ff.wlev[i];
                        end
                    end
                end
            endcase
        end
        // ----------------------------------------
        // start-up calibration
        // ----------------------------------------
        if (s_ff.calact && tick)
        begin
            nxt_s.caltk = s_ff.caltk + 9'h1;
            if (s_ff.calwait)
            begin
                // synchronized steps only begin on the phase wrap
                if (s_ff.unsynchronized_trim_select || s_ff.phase == 4'h0)
                begin
                    nxt_s.calwait = 1'b0;
                end
            end
            else if (s_ff.calcnt == 5'(aic_pkg::CAL_STEP_TICKS - 1))
            begin
                nxt_s.calcnt = 5'h0;
                if (s_ff.calstep == 4'(aic_pkg::CAL_STEPS - 1))
                begin
                    nxt_s.calact = 1'b0;
                    nxt_s.caldone = 1'b1;
                end
                else
                begin
                    nxt_s.calstep = s_ff.calstep + 4'h1;
                    // wait is at most one step long, so total stays within double
                    nxt_s.calwait = !s_ff.unsynchronized_trim_select;
                end
            end
            else
            begin
                nxt_s.calcnt = s_ff.calcnt + 5'h1;
            end
        end
        // ----------------------------------------
        // conversion sequence
        // ----------------------------------------
        case (s_ff.st)
            aic_pkg::CV_IDLE:
            begin
                if (ready)
                begin
                    nxt_s.chan = s_ff.qch;
                    nxt_s.cnt = 8'h0;
                    nxt_s.qval = s_ff.qrep;
                    if (wire_sel)
                    begin
                        nxt_s.st = aic_pkg::CV_PREP;
                        nxt_s.prechg = 1'b1;
                        nxt_s.prelvl = s_ff.wlev[s_ff.qch[1:0]];
                    end
                    else
                    begin
                        nxt_s.st = aic_pkg::CV_SAMPLE;
                        nxt_s.sample = 1'b1;
                    end
                end
            end
            aic_pkg::CV_PREP:
            begin
                if (tick && s_ff.cnt == 8'(aic_pkg::PREP_TICKS - 1))
                begin
                    nxt_s.prechg = 1'b0;
                    nxt_s.sample = 1'b1;
                    nxt_s.cnt = 8'h0;
                    nxt_s.st = aic_pkg::CV_SAMPLE;
                end
                else if (tick)
                begin
                    nxt_s.cnt = s_ff.cnt + 8'h1;
                end
            end
            aic_pkg::CV_SAMPLE:
            begin
                if (tick && s_ff.cnt == 8'(s_ff.iclass) + 8'(aic_pkg::SAMPLE_BASE - 1))
                begin
                    nxt_s.sample = 1'b0;
                    nxt_s.cnt = 8'h0;
                    nxt_s.st = aic_pkg::CV_CONV;
                end
                else if (tick)
                begin
                    nxt_s.cnt = s_ff.cnt + 8'h1;
                end
            end
            aic_pkg::CV_CONV:
            begin
                if (tick && s_ff.cnt == 8'(aic_pkg::CONV_TICKS - 1))
                begin
                    // an open wire leaves the precharge level on the capacitor
                    nxt_s.res = s_ff.din2;
                    nxt_s.resval = 1'b1;
                    nxt_s.srq = s_ff.srqen;
                    nxt_s.st = aic_pkg::CV_IDLE;
                end
                else if (tick)
                begin
                    nxt_s.cnt = s_ff.cnt + 8'h1;
                end
            end
            default: nxt_s.st = aic_pkg::CV_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_ff <= '0;
            s_ff.div <= aic_pkg::DIV_RST;
            s_ff.iclass <= aic_pkg::ICLASS_RST;
            s_ff.anaen <= aic_pkg::ANAEN_RST;
            s_ff.st <= aic_pkg::CV_IDLE;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign rdata = s_ff.rdata;
    assign ana_chan = s_ff.chan;
    assign ana_prechg = s_ff.prechg;
    assign ana_prelvl = s_ff.prelvl;
    assign ana_sample = s_ff.sample;
    assign srq0 = s_ff.srq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [7:0] h_smp;
    always_ff @(posedge sys_clk)
    begin
        if (rst || !s_ff.sample)
        begin
            h_smp <= 8'h0;
        end
        else if (tick)
        begin
            h_smp <= h_smp + 8'h1;
        end
    end

    a_cal_flag_set: assert property (wr && addr == aic_pkg::ADR_GLOBAL_CONFIG && ana_on
        && wdata[aic_pkg::START_BIT] && !s_ff.calact |=> s_ff.calact && !s_ff.caldone)
        else $error("cal not started");
    a_cal_flag_hold: assert property ($fell(s_ff.calact) |-> s_ff.caldone
        && $past(s_ff.calstep) == 4'(aic_pkg::CAL_STEPS - 1)) else $error("cal ended early");
    a_cal_bound: assert property (s_ff.calact
        |-> s_ff.caltk <= 9'(2 * aic_pkg::CAL_TICKS)) else $error("cal over double time");
    a_sync_wait: assert property (s_ff.calact && s_ff.calwait && !s_ff.unsynchronized_trim_select && tick
        && s_ff.phase != 4'h0 |=> s_ff.calwait && $stable(s_ff.calcnt))
        else $error("step began off sync point");
    a_cal_read: assert property (rd && addr == aic_pkg::ADR_ARBCFG
        |=> rdata[aic_pkg::CAL_BIT] == $past(s_ff.calact)) else $error("cal flag misread");
    a_auto_start: assert property (s_ff.st == aic_pkg::CV_IDLE && ready
        |=> s_ff.prechg || s_ff.sample) else $error("no auto conversion");
    a_prep_first: assert property ($rose(ana_sample) |-> $past(ana_prechg)
        || $past(s_ff.st) == aic_pkg::CV_IDLE && !$past(wire_sel))
        else $error("sample without precharge");
    a_prep_level: assert property ($rose(ana_prechg)
        |-> ana_prelvl == $past(s_ff.wlev[s_ff.qch[1:0]])) else $error("wrong precharge level");
    a_sample_len: assert property ($fell(ana_sample)
        |-> h_smp == 8'(s_ff.iclass) + 8'(aic_pkg::SAMPLE_BASE)) else $error("sample time wrong");
    a_result_store: assert property (s_ff.st == aic_pkg::CV_CONV && tick
        && s_ff.cnt == 8'(aic_pkg::CONV_TICKS - 1)
        |=> s_ff.res == $past(s_ff.din2) && srq0 == $past(s_ff.srqen))
        else $error("result not stored");
endmodule : aic_ctrl

// ### test/adc_init_and_wire_check_tb.sv
// Purpose: self-checking bench for the converter group init and wire-check block
// Assumes: register port strobes one cycle, bench drives ana_data as the analog side
// Notes: divider put back to zero for conversions, so phase lengths come out exact
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module adc_init_and_wire_check_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] ana_data = 12'h5a3;
    logic [31:0] rdata;
    logic [4:0] ana_chan;
    logic ana_prechg;
    logic ana_prelvl;
    logic ana_sample;
    logic srq0;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] rv;
    logic [4:0] ch;
    logic lv;
    int np;
    int ns;
    int nc;
    int n;

    always #5 sys_clk = ~sys_clk;

    aic_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ana_data(ana_data), .ana_chan(ana_chan),
        .ana_prechg(ana_prechg), .ana_prelvl(ana_prelvl), .ana_sample(ana_sample),
        .srq0(srq0));

    // ----------------------------------------
    // bus and timing helpers
    // ----------------------------------------
    task automatic cyc;
    begin
        @(posedge sys_clk);
        #1;
    end
    endtask : cyc

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    end
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    end
    endtask : reg_rd

    // polls the busy flag; granularity two cycles per read
    task automatic cal_wait(output int cnt);
    begin
        cnt = 0;
        reg_rd(aic_pkg::ADR_ARBCFG, rv);
        `CHK("cal flag set", 1'b1, rv[aic_pkg::CAL_BIT])
        while (rv[aic_pkg::CAL_BIT] === 1'b1 && cnt < 2400)
        begin
            reg_rd(aic_pkg::ADR_ARBCFG, rv);
            cnt = cnt + 2;
        end
    end
    endtask : cal_wait

    // waits for the next conversion start and times its phases
    task automatic meas;
    begin
        n = 0;
        while ((ana_prechg | ana_sample) !== 1'b0 && n < 200)
        begin
            cyc;
            n++;
        end
        while ((ana_prechg | ana_sample) !== 1'b1 && n < 400)
        begin
            cyc;
            n++;
        end
        lv = ana_prelvl;
        ch = ana_chan;
        np = 0;
        ns = 0;
        nc = 0;
        while (ana_prechg === 1'b1 && np < 100)
        begin
            np++;
            cyc;
        end
        while (ana_sample === 1'b1 && ns < 100)
        begin
            ns++;
            cyc;
        end
        while (srq0 !== 1'b1 && nc < 100)
        begin
            nc++;
            cyc;
        end
    end
    endtask : meas

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
    begin
        reg_rd(aic_pkg::ADR_ARBCFG, rv);
        `CHK("arbcfg reset", 32'h00000000, rv)
        reg_rd(aic_pkg::ADR_ANCFG, rv);
        `CHK("ancfg reset", 32'h00000000, rv)
        reg_wr(8'h3c, 32'hffffffff);
        reg_rd(8'h3c, rv);
        `CHK("unmapped read", 32'h00000000, rv)
        // calibration request with analog block off must be ignored
        reg_wr(aic_pkg::ADR_GLOBAL_CONFIG, 32'h80000000);
        reg_rd(aic_pkg::ADR_ARBCFG, rv);
        `CHK("cal refused", 1'b0, rv[aic_pkg::CAL_BIT])
        $display("test reset done");
    end
    endtask : test_reset

    task automatic test_startup;
    begin
        reg_wr(aic_pkg::ADR_ANCFG, 32'h00300000);
        reg_rd(aic_pkg::ADR_ANCFG, rv);
        `CHK("divider", 3'h3, rv[aic_pkg::DIV_MSB:aic_pkg::DIV_LSB])
        reg_wr(aic_pkg::ADR_ARBCFG, 32'h00000003);
        reg_rd(aic_pkg::ADR_ARBCFG, rv);
        `CHK("analog on", 2'h3, rv[1:0])
        `CHK("wakeup early", 1'b0, rv[aic_pkg::WU_BIT])
        repeat (aic_pkg::WU_CYC) cyc;
        reg_rd(aic_pkg::ADR_ARBCFG, rv);
        `CHK("wakeup done", 1'b1, rv[aic_pkg::WU_BIT])
        reg_wr(aic_pkg::ADR_GLOBAL_CONFIG, 32'h80000000);
        cal_wait(n);
        // divide by four: nominal 512 cycles, sync may double it
        `CHK("sync cal time", 1'b1, (n >= 508 && n <= 1040))
        reg_wr(aic_pkg::ADR_GLOBAL_CONFIG, 32'h80000002);
        cal_wait(n);
        `CHK("unsync cal time", 1'b1, (n >= 508 && n <= 522))
        $display("test startup done");
    end
    endtask : test_startup

    task automatic test_convert;
    begin
        reg_wr(aic_pkg::ADR_ANCFG, 32'h00000000);
        reg_wr(aic_pkg::ADR_ARBPR, 32'h01000000);
        reg_wr(aic_pkg::ADR_QMR0, 32'h00000001);
        reg_wr(aic_pkg::ADR_ICLASS0, 32'h00000002);
        reg_wr(aic_pkg::ADR_RCR0, 32'h80000000);
        reg_wr(aic_pkg::ADR_CHCTR, 32'h00000001);
        reg_wr(aic_pkg::ADR_QINR0, 32'h00000020);
        meas;
        `CHK("channel", 5'h00, ch)
        `CHK("prechg ticks", 2, np)
        `CHK("ground level", 1'b0, lv)
        `CHK("sample ticks", 4, ns)
        `CHK("conv to srq", 12, nc)
        reg_rd(aic_pkg::ADR_RES0, rv);
        `CHK("result", 12'h5a3, rv[11:0])
        `CHK("new flag", 1'b1, rv[aic_pkg::RESVAL_BIT])
        reg_rd(aic_pkg::ADR_RES0, rv);
        `CHK("flag cleared", 1'b0, rv[aic_pkg::RESVAL_BIT])
        for (int code = 0; code < 4; code++)
        begin
            reg_wr(aic_pkg::ADR_ICLASS0, code);
            meas;
            meas;
            `CHK("class sample", code + 2, ns)
        end
        $display("test convert done");
    end
    endtask : test_convert

    task automatic test_wire;
    begin
        reg_wr(aic_pkg::ADR_ICLASS0, 32'h00000002);
        reg_wr(aic_pkg::ADR_CHCTR, 32'h00000003);
        ana_data <= 12'hfff;
        meas;
        meas;
        `CHK("ref level", 1'b1, lv)
        `CHK("ref prechg", 2, np)
        reg_rd(aic_pkg::ADR_RES0, rv);
        `CHK("detached result", 12'hfff, rv[11:0])
        // wire check on another channel must leave channel zero plain
        reg_wr(aic_pkg::ADR_CHCTR, 32'h00000000);
        reg_wr(aic_pkg::ADR_CHCTR + 8'h04, 32'h00000001);
        meas;
        meas;
        `CHK("no prechg", 0, np)
        `CHK("plain sample", 4, ns)
        $display("test wire done");
    end
    endtask : test_wire

    task automatic test_no_srq;
    begin
        reg_wr(aic_pkg::ADR_RCR0, 32'h00000000);
        reg_rd(aic_pkg::ADR_RES0, rv);
        n = 0;
        repeat (60)
        begin
            cyc;
            if (srq0 !== 1'b0)
            begin
                n++;
            end
        end
        `CHK("srq masked", 0, n)
        reg_rd(aic_pkg::ADR_RES0, rv);
        `CHK("result still new", 1'b1, rv[aic_pkg::RESVAL_BIT])
        $display("test no_srq done");
    end
    endtask : test_no_srq

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic stop_test;
    begin
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    end
    endtask : stop_test

    // whole sequence needs about 2500 cycles
    initial
    begin
        #(30000 * 10);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        stop_test;
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset;
        test_startup;
        test_convert;
        test_wire;
        test_no_srq;
        stop_test;
    end
endmodule : adc_init_and_wire_check_tb
